/* rtl/hps_host.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hps_consts.svh"
module hps_host (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  hps_bus_if.host         bus,
  input  wire logic       bus_mux,
  input  wire logic       bus_rdwr,
  input  wire logic       a7_is_address,
  input  wire logic       reset_req,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output var  logic       cmd_ready,
  output var  logic       rsp_valid,
  output var  logic [7:0] rsp_rdata
);

  typedef struct packed {
    hps_pkg::hps_host_state_type state;
    logic [3:0] cnt;
    logic       cs_n;
    logic       ds_rd;
    logic       rw_wr;
    logic       astb;
    logic       mode;
    logic       style;
    logic [2:0] low;
    logic [3:0] mid;
    logic       a7_o;
    logic       a7_oe;
    logic [7:0] data_o;
    logic       data_oe;
    logic       dev_rst_n;
    logic       ack_s1;
    logic       ack_s2;
    logic [7:0] dat_s1;
    logic [7:0] dat_s2;
    logic       write;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ready;
    logic       rsp;
  } hps_host_reg_type;

  hps_host_reg_type s_reg;
  hps_host_reg_type s_next;
  logic             hold_done;
  logic             rdwr;

  always_comb begin
    s_next = s_reg;
    s_next.ack_s1 = bus.transfer_ack_n;
    s_next.ack_s2 = s_reg.ack_s1;
    s_next.dat_s1 = bus.host_data_bus;
    s_next.dat_s2 = s_reg.dat_s1;
    s_next.rsp = 1'b0;
    s_next.cnt = s_reg.cnt + 4'h1;
    hold_done = (s_reg.cnt == `HPS_HOLD_CYCLES);
    rdwr = s_reg.mode & s_reg.style;

    case (s_reg.state)
      hps_pkg::HST_RST: begin
        s_next.dev_rst_n = 1'b0;
        if (s_reg.cnt >= 4'(`HPS_RESET_CYCLES - 1)) begin
          s_next.dev_rst_n = 1'b1;                            // [RQ3]
          s_next.ready     = 1'b1;
          s_next.state     = hps_pkg::HST_IDLE;
        end
      end
      hps_pkg::HST_IDLE: begin
        s_next.mode  = bus_mux;
        s_next.style = bus_rdwr;
        s_next.cs_n  = 1'b1;
        s_next.ds_rd = bus_mux & bus_rdwr;
        s_next.rw_wr = 1'b1;
        s_next.cnt   = 4'h0;
        if (reset_req) begin
          s_next.dev_rst_n = 1'b0;                            // [RQ3]
          s_next.ready     = 1'b0;
          s_next.state     = hps_pkg::HST_RST;
        end else if (cmd_valid && s_reg.ready) begin
          s_next.ready = 1'b0;
          s_next.write = cmd_write;
          s_next.wdata = cmd_wdata;
          if (s_reg.mode) begin
            s_next.data_o  = cmd_addr;
            s_next.data_oe = 1'b1;
            s_next.astb    = 1'b1;
            s_next.state   = hps_pkg::HST_ADDR;
          end else begin
            s_next.low   = cmd_addr[2:0];
            s_next.mid   = cmd_addr[6:3];
            s_next.a7_o  = cmd_addr[7];
            s_next.a7_oe = a7_is_address;
            s_next.state = hps_pkg::HST_SETUP;
          end
        end
      end
      hps_pkg::HST_ADDR: begin
        if (hold_done) begin
          s_next.astb  = 1'b0;
          s_next.cnt   = 4'h0;
          s_next.state = hps_pkg::HST_ALAT;
        end
      end
      hps_pkg::HST_ALAT: begin
        if (hold_done) begin
          s_next.data_oe = 1'b0;
          s_next.cnt     = 4'h0;
          s_next.state   = hps_pkg::HST_SETUP;
        end
      end
      hps_pkg::HST_SETUP: begin
        s_next.rw_wr   = rdwr ? 1'b1 : !s_reg.write;          // [RQ10]
        s_next.data_o  = s_reg.wdata;
        s_next.data_oe = s_reg.write;
        if (hold_done) begin
          s_next.cs_n  = 1'b0;                                // [RQ12]
          s_next.state = hps_pkg::HST_STRB;
          if (rdwr) begin
            s_next.ds_rd = s_reg.write;
            s_next.rw_wr = !s_reg.write;
          end else begin
            s_next.ds_rd = 1'b1;                              // [RQ8]
          end
        end
      end
      hps_pkg::HST_STRB: begin
        if (!s_reg.ack_s2) begin
          s_next.rdata = s_reg.dat_s2;
          s_next.cs_n  = 1'b1;
          s_next.ds_rd = rdwr;
          s_next.rw_wr = 1'b1;
          s_next.state = hps_pkg::HST_REL;
        end
      end
      hps_pkg::HST_REL: begin
        if (s_reg.ack_s2) begin
          s_next.data_oe = 1'b0;
          s_next.a7_oe   = 1'b0;
          s_next.rsp     = 1'b1;
          s_next.ready   = 1'b1;
          s_next.state   = hps_pkg::HST_IDLE;
        end
      end
      default: begin
        s_next.state = hps_pkg::HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg        <= '0;                                     // [RQ3]
      s_reg.state  <= hps_pkg::HST_RST;
      s_reg.cs_n   <= 1'b1;
      s_reg.rw_wr  <= 1'b1;
      s_reg.ack_s1 <= 1'b1;
      s_reg.ack_s2 <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.cs_n                 = s_reg.cs_n;
  assign bus.ds_rd                = s_reg.ds_rd;
  assign bus.rw_wr                = s_reg.rw_wr;
  assign bus.address_strobe       = s_reg.astb;
  assign bus.host_bus_mode_pin    = s_reg.mode;
  assign bus.rdwr_style           = s_reg.style;
  assign bus.low_register_address = s_reg.low;
  assign bus.mid_address          = s_reg.mid;
  assign bus.host_a7_o            = s_reg.a7_o;
  assign bus.host_a7_oe           = s_reg.a7_oe;
  assign bus.host_data_o          = s_reg.data_o;
  assign bus.host_data_oe         = s_reg.data_oe;
  assign bus.dev_rst_n            = s_reg.dev_rst_n;
  assign cmd_ready                = s_reg.ready;
  assign rsp_valid                = s_reg.rsp;
  assign rsp_rdata                = s_reg.rdata;

endmodule // hps_host
`default_nettype wire

/* rtl/hps_consts.svh */
// Operation
// RQ1: Reset low clears all counters and registers; the frame run counter instead loads its maximum (HPS_RUN_MAX); code sets DEV_IDLE and idle select
// RQ2: Serial outputs float while reset is held
// RQ3: Host holds reset low at least 100 ns
// RQ4: Frame pulse format identified automatically
// RQ5: Serial clock rate follows speed select register
// RQ6: Non-multiplexed bus: shared pins are address 0-2
// RQ7: 16x8 configuration: shared pins are serial inputs
// RQ8: Strobe modes: access needs strobe and select
// RQ9: Read strobe low drives data bus outward
// RQ10: Direction input chooses read or write
// RQ11: Write strobe low takes data bus inward
// RQ12: Accesses happen only under chip select
// RQ13: Data bus reaches registers and memories
// RQ14: Multiplexed bus: address taken from data bus
// RQ15: Pin seven: address bit or serial output
// RQ16: Address strobe falling edge latches address
// RQ17: Mode pin high selects multiplexed bus
// RQ18: Open-drain acknowledge marks finished transfer
// RQ19: Latched address held until select released
`ifndef HPS_CONSTS_SVH
`define HPS_CONSTS_SVH

`define HPS_IDX_CTRL        0
`define HPS_IDX_SPEED       1
`define HPS_SPD_RATE8_BIT   0
`define HPS_SPD_CFG16_BIT   1
`define HPS_FRAME_PULSE_MAX 8'h04
`define HPS_RUN_MAX         8'hFF
`define HPS_BUS_IDLE        8'hFF
`define HPS_HOLD_CYCLES     4'h3
`define HPS_CLK_PERIOD_NS   100
`define HPS_RESET_MIN_NS    100
`define HPS_RESET_CYCLES    ((`HPS_RESET_MIN_NS + `HPS_CLK_PERIOD_NS - 1) / `HPS_CLK_PERIOD_NS)

`endif

/* rtl/hps_pkg.sv */
package hps_pkg;

  typedef struct packed {
    logic       cs_n;
    logic       ds_rd;
    logic       rw_wr;
    logic       astb;
    logic       mode;
    logic       style;
    logic [2:0] low;
    logic [3:0] mid;
    logic       a7;
    logic [7:0] data;
    logic       frame;
  } hps_pins_type;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'h1,
    DEV_ACC  = 3'h2,
    DEV_ACK  = 3'h4
  } hps_dev_state_type;

  typedef enum logic [6:0] {
    HST_RST   = 7'h01,
    HST_IDLE  = 7'h02,
    HST_ADDR  = 7'h04,
    HST_ALAT  = 7'h08,
    HST_SETUP = 7'h10,
    HST_STRB  = 7'h20,
    HST_REL   = 7'h40
  } hps_host_state_type;

endpackage

/* rtl/hps_bus_if.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hps_consts.svh"
interface hps_bus_if;
  logic       cs_n;
  logic       ds_rd;
  logic       rw_wr;
  logic       address_strobe;
  logic       host_bus_mode_pin;
  logic       rdwr_style;
  logic [2:0] low_register_address;
  logic [3:0] mid_address;
  logic       host_a7_o;
  logic       host_a7_oe;
  logic [7:0] host_data_o;
  logic       host_data_oe;
  logic       dev_rst_n;
  logic [7:0] dev_data_o;
  logic       dev_data_oe;
  logic       ack_oe;
  logic       serial_out_seven;
  logic       serial_out_seven_oe;
  logic [7:0] host_data_bus;
  logic       transfer_ack_n;
  logic       address_bit_seven;

  // Wire levels: pull-ups on data and acknowledge, pin seven pulled low
  assign host_data_bus = dev_data_oe ? dev_data_o :
                         (host_data_oe ? host_data_o : `HPS_BUS_IDLE);
  assign transfer_ack_n = ack_oe ? 1'b0 : 1'b1;
  assign address_bit_seven = serial_out_seven_oe ? serial_out_seven :
                             (host_a7_oe ? host_a7_o : 1'b0);

  modport dev (
    input  cs_n, ds_rd, rw_wr, address_strobe, host_bus_mode_pin, rdwr_style,
    input  low_register_address, mid_address, host_data_bus, address_bit_seven,
    output dev_data_o, dev_data_oe, ack_oe, serial_out_seven, serial_out_seven_oe
  );
  modport host (
    output cs_n, ds_rd, rw_wr, address_strobe, host_bus_mode_pin, rdwr_style,
    output low_register_address, mid_address, host_a7_o, host_a7_oe,
    output host_data_o, host_data_oe, dev_rst_n,
    input  host_data_bus, transfer_ack_n
  );
endinterface // hps_bus_if
`default_nettype wire

/* rtl/hps_device.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hps_consts.svh"
module hps_device #(
  parameter int MEM_WORDS = 32
) (
  input  wire logic  mclk,
  input  wire logic  rst_b,
  hps_bus_if.dev     bus,
  input  wire logic  frame_sync_in,
  input  wire logic  serial_out_seven_data,
  output var  logic  rate_8m,
  output var  logic  cfg_16x8,
  output var  logic [2:0] serial_in_eight_ten,
  output var  logic  frame_pulse,
  output var  logic  frame_is_gci,
  output var  logic [7:0] ctrl_value
);

  localparam int AW = $clog2(MEM_WORDS);

  typedef struct packed {
    hps_pkg::hps_pins_type         sy1;
    hps_pkg::hps_pins_type         sy2;
    logic                          as_prev;
    hps_pkg::hps_dev_state_type    state;
    logic                          is_read;
    logic [7:0]                    addr_latch;
    logic [7:0]                    addr_cur;
    logic [MEM_WORDS-1:0][7:0]     mem;
    logic [7:0]                    data_o;
    logic                          data_oe;
    logic                          ack_oe;
    logic                          st7_o;
    logic                          st7_oe;
    logic                          rate8;
    logic                          cfg16;
    logic [7:0]                    ctrl;
    logic [2:0]                    serial_low;
    logic                          fr_prev;
    logic [7:0]                    run_cnt;
    logic                          gci;
    logic                          fr_pulse;
  } hps_dev_reg_type;

  hps_dev_reg_type       s_reg;
  hps_dev_reg_type       s_next;
  hps_pkg::hps_pins_type pins_now;
  logic                  mux;
  logic                  rdwr;
  logic                  rd;
  logic                  wr;
  logic                  active;
  logic                  a7_addr;
  logic [7:0]            addr_eff;
  logic [AW-1:0]         idx;

  always_comb begin
    pins_now.cs_n  = bus.cs_n;
    pins_now.ds_rd = bus.ds_rd;
    pins_now.rw_wr = bus.rw_wr;
    pins_now.astb  = bus.address_strobe;
    pins_now.mode  = bus.host_bus_mode_pin;
    pins_now.style = bus.rdwr_style;
    pins_now.low   = bus.low_register_address;
    pins_now.mid   = bus.mid_address;
    pins_now.a7    = bus.address_bit_seven;
    pins_now.data  = bus.host_data_bus;
    pins_now.frame = frame_sync_in;
  end

  always_comb begin
    s_next = s_reg;
    s_next.sy1 = pins_now;
    s_next.sy2 = s_reg.sy1;
    s_next.fr_pulse = 1'b0;

    mux  = s_reg.sy2.mode;                                    // [RQ17]
    rdwr = mux & s_reg.sy2.style;
    if (rdwr) begin
      rd     = !s_reg.sy2.ds_rd;                              // [RQ9]
      wr     = !s_reg.sy2.rw_wr;                              // [RQ11]
      active = !s_reg.sy2.cs_n & (rd | wr);                   // [RQ12]
    end else begin
      rd     = s_reg.sy2.rw_wr;                               // [RQ10]
      wr     = !s_reg.sy2.rw_wr;
      active = !s_reg.sy2.cs_n & s_reg.sy2.ds_rd;             // [RQ8] [RQ12]
    end

    // Pin seven is an address input only without multiplexing at the fast rate
    a7_addr = !mux & s_reg.rate8;                             // [RQ15]
    if (mux) begin
      addr_eff = s_reg.addr_latch;                            // [RQ14]
    end else begin
      addr_eff = {a7_addr & s_reg.sy2.a7, s_reg.sy2.mid, s_reg.sy2.low}; // [RQ6]
    end
    idx = s_reg.addr_cur[AW-1:0];

    // Latch only between accesses so the address stays put under select
    s_next.as_prev = s_reg.sy2.astb;
    if (mux && s_reg.as_prev && !s_reg.sy2.astb &&
        s_reg.state == hps_pkg::DEV_IDLE && s_reg.sy2.cs_n) begin
      s_next.addr_latch = s_reg.sy2.data;                     // [RQ16] [RQ19]
    end

    case (s_reg.state)
      hps_pkg::DEV_IDLE: begin
        if (active) begin
          s_next.state    = hps_pkg::DEV_ACC;
          s_next.is_read  = rd;
          s_next.addr_cur = addr_eff;
        end
      end
      hps_pkg::DEV_ACC: begin
        if (s_reg.is_read) begin
          s_next.data_o  = s_reg.mem[idx];                    // [RQ13]
          s_next.data_oe = 1'b1;                              // [RQ9]
        end else begin
          s_next.mem[idx] = s_reg.sy2.data;                   // [RQ11] [RQ13]
        end
        s_next.ack_oe = 1'b1;                                 // [RQ18]
        s_next.state  = hps_pkg::DEV_ACK;
      end
      hps_pkg::DEV_ACK: begin
        if (!active) begin
          s_next.ack_oe  = 1'b0;                              // [RQ18]
          s_next.data_oe = 1'b0;
          s_next.state   = hps_pkg::DEV_IDLE;
        end
      end
      default: begin
        s_next.state   = hps_pkg::DEV_IDLE;
        s_next.ack_oe  = 1'b0;
        s_next.data_oe = 1'b0;
      end
    endcase

    s_next.rate8 = s_next.mem[`HPS_IDX_SPEED][`HPS_SPD_RATE8_BIT];  // [RQ5]
    s_next.cfg16 = s_next.mem[`HPS_IDX_SPEED][`HPS_SPD_CFG16_BIT];
    s_next.ctrl  = s_next.mem[`HPS_IDX_CTRL];

    s_next.st7_oe = !a7_addr;                                 // [RQ15]
    s_next.st7_o  = serial_out_seven_data;
    s_next.serial_low = s_reg.cfg16 ? s_reg.sy2.low : 3'h0;   // [RQ7]

    // A short run of one level is the pulse; its level names the format
    s_next.fr_prev = s_reg.sy2.frame;
    if (s_reg.sy2.frame != s_reg.fr_prev) begin
      if (s_reg.run_cnt < `HPS_FRAME_PULSE_MAX) begin
        s_next.gci      = s_reg.fr_prev;                      // [RQ4]
        s_next.fr_pulse = 1'b1;
      end
      s_next.run_cnt = 8'h00;
    end else if (s_reg.run_cnt != `HPS_RUN_MAX) begin
      s_next.run_cnt = s_reg.run_cnt + 8'h01;
    end
  end

  // Reset clears all but the run counter, which loads its maximum, and the state, which loads DEV_IDLE; pin seven floats; select reads as idle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg          <= '0;                                   // [RQ1] [RQ2]
      s_reg.state    <= hps_pkg::DEV_IDLE;
      s_reg.sy1.cs_n <= 1'b1;
      s_reg.sy2.cs_n <= 1'b1;
      s_reg.run_cnt  <= `HPS_RUN_MAX;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.dev_data_o          = s_reg.data_o;
  assign bus.dev_data_oe         = s_reg.data_oe;
  assign bus.ack_oe              = s_reg.ack_oe;
  assign bus.serial_out_seven    = s_reg.st7_o;
  assign bus.serial_out_seven_oe = s_reg.st7_oe;
  assign rate_8m                 = s_reg.rate8;
  assign cfg_16x8                = s_reg.cfg16;
  assign serial_in_eight_ten     = s_reg.serial_low;
  assign frame_pulse             = s_reg.fr_pulse;
  assign frame_is_gci            = s_reg.gci;
  assign ctrl_value              = s_reg.ctrl;

endmodule // hps_device
`default_nettype wire

/* tb/hps_bus_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module hps_bus_assertions (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       dev_rst_n,
  input wire logic       cs_n,
  input wire logic       ds_rd,
  input wire logic       rw_wr,
  input wire logic       address_strobe,
  input wire logic       host_bus_mode_pin,
  input wire logic       rdwr_style,
  input wire logic [2:0] low_register_address,
  input wire logic [3:0] mid_address,
  input wire logic       host_data_oe,
  input wire logic       dev_data_oe,
  input wire logic       ack_oe,
  input wire logic       serial_out_seven_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!dev_rst_n);
  sequence s_addr_phase;
    (address_strobe && host_data_oe)[*4] ##1 !address_strobe;
  endsequence
  sequence s_mode_held;
    host_bus_mode_pin[*4];
  endsequence
  AST_RESET_FLOAT: assert property (disable iff (!rst_b)
    !dev_rst_n |-> !serial_out_seven_oe && !dev_data_oe && !ack_oe) else $error("busy in reset");
  AST_ACK_UNDER_SELECT: assert property (
    $rose(ack_oe) |-> !cs_n) else $error("ack without select");
  AST_STROBE_WITH_SELECT: assert property (
    $rose(ack_oe) && !(host_bus_mode_pin && rdwr_style) |-> ds_rd) else $error("ack without strobe");
  AST_DRIVE_ON_READ: assert property (
    $rose(dev_data_oe) |-> !cs_n && ((host_bus_mode_pin && rdwr_style) ? !ds_rd : rw_wr))
    else $error("data driven outside read");
  AST_NO_DRIVE_ON_WRITE: assert property (
    ack_oe && !rw_wr |-> !dev_data_oe) else $error("data driven during write");
  AST_ACK_WITHIN: assert property (
    $rose(ds_rd) && !cs_n && !host_bus_mode_pin |-> ##[1:8] ack_oe) else $error("ack late");
  AST_ACK_RELEASE: assert property (
    $rose(cs_n) |-> ##[1:8] !ack_oe) else $error("ack stuck");
  AST_ADDR_HELD: assert property (
    !cs_n && !$past(cs_n) |-> $stable(low_register_address) && $stable(mid_address))
    else $error("address moved in access");
  AST_AS_IDLE_NONMUX: assert property (
    !host_bus_mode_pin && !$past(host_bus_mode_pin) |-> !address_strobe)
    else $error("strobe active in direct mode");
  AST_MUX_ADDR: assert property (
    $rose(address_strobe) |-> s_addr_phase) else $error("bad address phase");
  AST_PIN7_MUX: assert property (
    s_mode_held |-> serial_out_seven_oe) else $error("pin seven not output");
endmodule // hps_bus_assertions
`default_nettype wire

/* tb/host_port_pin_sharing_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module host_port_pin_sharing_tb;
  logic       mclk, rst_b, bus_mux, bus_rdwr, a7_is_address, reset_req;
  logic       cmd_valid, cmd_write, cmd_ready, rsp_valid, frame_sync_in, s7_data;
  logic       rate_8m, cfg_16x8, frame_pulse, frame_is_gci;
  logic [7:0] cmd_addr, cmd_wdata, rsp_rdata, rd, ctrl_value;
  logic [2:0] sin_8_10;
  wire logic  dev_rst;
  int         n_errors, n_compared;
  hps_bus_if bus ();
  assign dev_rst = bus.dev_rst_n & rst_b;
  hps_device #(.MEM_WORDS(32)) i_hps_device (.mclk, .rst_b(dev_rst), .bus(bus), .frame_sync_in,
    .serial_out_seven_data(s7_data), .rate_8m, .cfg_16x8, .serial_in_eight_ten(sin_8_10),
    .frame_pulse, .frame_is_gci, .ctrl_value);
  hps_host i_hps_host (.mclk, .rst_b, .bus(bus), .bus_mux, .bus_rdwr, .a7_is_address, .reset_req,
    .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata);
  hps_bus_assertions i_hps_bus_assertions (.mclk, .rst_b, .dev_rst_n(bus.dev_rst_n),
    .cs_n(bus.cs_n), .ds_rd(bus.ds_rd), .rw_wr(bus.rw_wr), .address_strobe(bus.address_strobe),
    .host_bus_mode_pin(bus.host_bus_mode_pin), .rdwr_style(bus.rdwr_style),
    .low_register_address(bus.low_register_address), .mid_address(bus.mid_address),
    .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe), .ack_oe(bus.ack_oe),
    .serial_out_seven_oe(bus.serial_out_seven_oe));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic tally_and_finish;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic give_up;
    n_errors++;
    tally_and_finish();
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One host command; waits for take and for the response pulse
  task automatic host_cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge mclk);
      if (cmd_ready === 1'b1) break;
    end
    if (i == 100) give_up();
    cmd_valid <= 1'b0;
    for (i = 0; i < 100; i++) begin
      @(posedge mclk);
      if (rsp_valid === 1'b1) break;
    end
    if (i == 100) give_up();
    rd = rsp_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host_cmd(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask
  task automatic t_reset;
    cycles(10);
    `CHK(bus.serial_out_seven_oe, 1'b0)
    `CHK(bus.dev_data_oe, 1'b0)
    cycles(10);
    rst_b <= 1'b1;
    #1 `CHK(bus.dev_rst_n, 1'b0)
    @(posedge mclk);
    #1 `CHK(bus.dev_rst_n, 1'b1)
    @(posedge mclk);
    rd_chk(8'h00, 8'h00);
  endtask
  task automatic t_nonmux;
    host_cmd(1'b1, 8'h00, 8'hA5);
    `CHK(ctrl_value, 8'hA5)
    host_cmd(1'b1, 8'h05, 8'h5A);
    rd_chk(8'h05, 8'h5A);
    rd_chk(8'h00, 8'hA5);
    rd_chk(8'h04, 8'h00);
  endtask
  task automatic t_mux;
    for (int i = 0; i < 2; i++) begin
      bus_mux <= 1'b1;
      bus_rdwr <= i[0];
      @(posedge mclk);
      host_cmd(1'b1, 8'h12 + 8'(i), 8'h3C ^ 8'(i));
      rd_chk(8'h12 + 8'(i), 8'h3C ^ 8'(i));
    end
    `CHK(bus.serial_out_seven_oe, 1'b1)
    s7_data <= 1'b1;
    cycles(4);
    `CHK(bus.address_bit_seven, 1'b1)
    s7_data <= 1'b0;
    cycles(4);
    `CHK(bus.address_bit_seven, 1'b0)
    bus_mux <= 1'b0;
    @(posedge mclk);
    rd_chk(8'h13, 8'h3D);
  endtask
  task automatic t_speed;
    host_cmd(1'b1, 8'h01, 8'h01);
    a7_is_address <= 1'b1;
    cycles(4);
    `CHK(rate_8m, 1'b1)
    `CHK(bus.serial_out_seven_oe, 1'b0)
    host_cmd(1'b1, 8'h01, 8'h03);
    cycles(4);
    `CHK(cfg_16x8, 1'b1)
    `CHK(sin_8_10, 3'h1)
    a7_is_address <= 1'b0;
    host_cmd(1'b1, 8'h01, 8'h00);
    cycles(4);
    `CHK(rate_8m, 1'b0)
    `CHK(sin_8_10, 3'h0)
    `CHK(bus.serial_out_seven_oe, 1'b1)
  endtask
  task automatic wait_pulse(input logic e);
    int i;
    for (i = 0; i < 12; i++) begin
      @(posedge mclk);
      if (frame_pulse === 1'b1) break;
    end
    if (i == 12) give_up();
    @(posedge mclk);
    `CHK(frame_is_gci, e)
  endtask
  task automatic t_frame;
    frame_sync_in <= 1'b1;
    cycles(2);
    frame_sync_in <= 1'b0;
    wait_pulse(1'b1);
    cycles(10);
    frame_sync_in <= 1'b1;
    cycles(10);
    frame_sync_in <= 1'b0;
    cycles(2);
    frame_sync_in <= 1'b1;
    wait_pulse(1'b0);
  endtask
  task automatic t_softreset;
    reset_req <= 1'b1;
    @(posedge mclk);
    reset_req <= 1'b0;
    #1 `CHK(bus.dev_rst_n, 1'b0)
    @(posedge mclk);
    rd_chk(8'h00, 8'h00);
    `CHK(ctrl_value, 8'h00)
  endtask
  initial begin
    rst_b = 1'b0;
    bus_mux = 1'b0;
    bus_rdwr = 1'b0;
    a7_is_address = 1'b0;
    reset_req = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 8'h00;
    cmd_wdata = 8'h00;
    frame_sync_in = 1'b0;
    s7_data = 1'b0;
    n_errors = 0;
    n_compared = 0;
    t_reset();
    t_nonmux();
    t_mux();
    t_speed();
    t_frame();
    t_softreset();
    tally_and_finish();
  end
endmodule // host_port_pin_sharing_tb
`default_nettype wire
